// [csfc_clk_switch.sv]
`timescale 1ns/1ns
`default_nettype none
module csfc_clk_switch
    import csfc_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    input  wire logic [2:0] i_src_lvl,
    input  wire logic [1:0] i_sel,
    output logic            o_clk,
    output logic [1:0]      o_cur
);
    typedef enum logic [1:0] {SW_RUN, SW_FINISH, SW_HOLD} csfc_sw_state_type;

    csfc_sw_state_type state_reg;
    logic [2:0]        prev_reg;
    logic [2:0]        rise;

    // level of one source, unknown codes fall back to the ring
    function automatic logic pick(input logic [2:0] lvl, input logic [1:0] sel);
        pick = (sel == SRC_XT1) ? lvl[1] : (sel == SRC_XT2) ? lvl[2] : lvl[0];
    endfunction

    assign rise = i_src_lvl & ~prev_reg;

    // previous levels for edge detection
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_reg <= 3'h0;
        end else begin
            prev_reg <= i_src_lvl;
        end
    end

    // finish old cycle, park high, resume on the new rising edge
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= SW_RUN;
            o_cur     <= SRC_RING;
            o_clk     <= 1'b0;
        end else begin
            case (state_reg)
                SW_RUN: begin
                    o_clk <= pick(i_src_lvl, o_cur);
                    if (i_sel != o_cur) begin
                        state_reg <= SW_FINISH; // RULE20
                    end
                end
                SW_FINISH: begin
                    if (pick(rise, o_cur)) begin
                        o_clk     <= 1'b1; // RULE20
                        state_reg <= SW_HOLD;
                    end else begin
                        o_clk <= pick(i_src_lvl, o_cur);
                    end
                end
                SW_HOLD: begin
                    // no short pulse can escape while parked high
                    o_clk <= 1'b1;
                    if (pick(rise, i_sel)) begin
                        o_cur     <= i_sel; // RULE20
                        state_reg <= SW_RUN;
                    end
                end
                default: begin
                    state_reg <= SW_RUN;
                end
            endcase
        end
    end

    hold_high_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE20
        state_reg == SW_HOLD |=> o_clk)
        else $error("switch output fell while parked high");
endmodule // csfc_clk_switch
`default_nettype wire

// [csfc_osc_model.sv]
`timescale 1ns/1ns
`default_nettype none
// crystal and ring stand-ins; a stopped or stalled source freezes its level
module csfc_osc_model #(
    parameter int H1 = 3,
    parameter int H2 = 2
) (
    input  wire logic i_clk_sys,
    input  wire logic i_en1,
    input  wire logic i_en2,
    input  wire logic i_enr,
    input  wire logic i_stall,
    output logic      o_x1 = 1'b0,
    output logic      o_x2 = 1'b0,
    output logic      o_ring = 1'b0
);
    int c1 = 0;
    int c2 = 0;
    // ring toggles each cycle, crystals slower so edges are sparse
    always @(posedge i_clk_sys) begin
        c1 <= c1 + int'(i_en1 && !i_stall);
        c2 <= c2 + int'(i_en2);
        if (i_en1 && !i_stall && c1 % H1 == 0) begin
            o_x1 <= ~o_x1;
        end
        if (i_en2 && c2 % H2 == 0) begin
            o_x2 <= ~o_x2;
        end
        if (i_enr) begin
            o_ring <= ~o_ring;
        end
    end
endmodule // csfc_osc_model
`default_nettype wire

// [csfc_pkg.sv]
package csfc_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DCO  = 8'h04;
    localparam logic [7:0] ADDR_CSEL = 8'h08;
    localparam logic [7:0] ADDR_IE   = 8'h0c;
    localparam logic [7:0] ADDR_IFG  = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;
    // control register bit positions
    localparam int CTRL_SPEED = 0;
    localparam int CTRL_X1OFF = 1;
    localparam int CTRL_X2OFF = 2;
    localparam int CTRL_ROFF  = 3;
    localparam int CTRL_RES   = 4;
    // oscillator setting field positions
    localparam int DCO_STEP_LSB  = 0;
    localparam int DCO_MOD_LSB   = 3;
    localparam int DCO_RANGE_LSB = 8;
    // main select in [1:0], submain select in bit 2
    localparam int CSEL_SUB = 2;
    // enable and flag position
    localparam int FLAG_BIT = 1;
    // values after reset, highest step and last modulation phase
    localparam logic [4:0] CTRL_RST  = 5'h00;
    localparam logic [2:0] RANGE_RST = 3'h4;
    localparam logic [2:0] STEP_RST  = 3'h3;
    localparam logic [4:0] MOD_RST   = 5'h00;
    localparam logic [2:0] STEP_MAX  = 3'h7;
    localparam logic [4:0] PHASE_END = 5'h1f;
    // clock source codes
    localparam logic [1:0] SRC_RING = 2'h0;
    localparam logic [1:0] SRC_XT1  = 2'h1;
    localparam logic [1:0] SRC_XT2  = 2'h2;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned FAULT_TIME_NS = 50000;
    localparam int unsigned FAULT_CYCLES  = FAULT_TIME_NS / CLK_PERIOD_NS;
endpackage

// [csfc_top.sv]
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RULE1 - speed select bit 0 runs crystal one low-speed, 1 high-speed
// RULE2 - crystal one off bit stops it only when no clock uses it
// RULE3 - crystal two off bit stops it only when no clock uses it
// RULE4 - ring off bit stops ring only when no clock uses it
// RULE5 - software keeps off bit clear when a crystal input is external
// RULE6 - reset: internal resistor, range 4, step 3, both clocks on ring
// RULE7 - resistor select bit picks internal or external resistor
// RULE8 - three-bit range and three-bit step fields select ring frequency
// RULE9 - modulation has no effect when step is 7
// RULE10 - count cycles of 32 use higher step; count 0 disables modulation
// RULE11 - fault when high-speed crystal one or crystal two absent 50 us
// RULE12 - on fault, main clock on a monitored crystal moves to ring
// RULE13 - interrupt request while fault flag and its enable both set
// RULE14 - hardware never clears the fault flag; software clears it
// RULE15 - no fault detection for crystal one in low-speed mode
// RULE16 - fault signal high at power-on and on faults; it sets flag; without crystal two it is low at power-on, reset sets the flag
// RULE17 - stopped crystal: fault at once, clears 50 us after restart
// RULE18 - without crystal two, flag cannot clear in low-speed mode
// RULE19 - with crystal two, clearing sticks; low-speed selection ignores flag
// RULE20 - source change: finish cycle, hold high, start on new edge
// RULE21 - fault flag sits at bit 1 of the flag register
// RULE22 - higher-step cycles spread evenly over each 32-cycle period
module csfc_top
    import csfc_pkg::*;
#(
    parameter bit          HAS_XT2   = 1'b1,
    parameter int unsigned FAULT_CYC = FAULT_CYCLES
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_crystal_one_clock,
    input  wire logic        i_crystal_two_clock,
    input  wire logic        i_ring_osc_clock,
    input  wire logic        i_active_mode,
    output logic             o_crystal_one_en,
    output logic             o_crystal_one_hf,
    output logic             o_crystal_two_en,
    output logic             o_ring_osc_en,
    output logic             o_resistor_ext,
    output logic [2:0]       o_range_select,
    output logic [2:0]       o_ring_step,
    output logic             o_main_clock,
    output logic             o_submain_clock,
    output logic             o_nmi_req
);
    logic       rst_meta_reg;
    logic       rst_n;
    logic [4:0] ctrl_reg;
    logic [2:0] step_reg;
    logic [4:0] mod_reg;
    logic [2:0] range_reg;
    logic [1:0] main_sel_reg;
    logic       sub_sel_reg;
    logic       ie_reg;
    logic       flag_reg;
    logic [1:0] prev_reg;
    logic       ring_prev_reg;
    logic [15:0] absent_reg [2];
    logic [15:0] good_reg [2];
    logic [1:0] fault_reg;
    logic [4:0] phase_reg;
    logic [4:0] acc_reg;
    logic [5:0] acc_next;
    logic       hi_step;
    logic       speed_hf;
    logic [1:0] mon_on;
    logic [1:0] osc_run;
    logic [1:0] osc_edge;
    logic       fault_sig;
    logic [1:0] main_req;
    logic [1:0] main_eff;
    logic [1:0] sub_eff;
    logic [1:0] main_cur;
    logic [1:0] sub_cur;
    logic       x1_used;
    logic       x2_used;
    logic       ring_used;
    logic       setup;
    logic       wr_acc;
    logic       flag_clr;
    logic [2:0] main_lvl;

    // a crystal source is watched by the fault detector
    function automatic logic monitored(input logic [1:0] src, input logic hf);
        monitored = (src == SRC_XT2) || ((src == SRC_XT1) && hf);
    endfunction

    // without crystal two its code falls back to crystal one
    function automatic logic [1:0] map_src(input logic [1:0] src);
        map_src = (src == SRC_XT2 && !HAS_XT2) ? SRC_XT1 : src;
    endfunction

    // a source feeds a clock now or after a pending switch
    function automatic logic in_use(input logic [1:0] src, input logic [1:0] a,
                                    input logic [1:0] b, input logic [1:0] c,
                                    input logic [1:0] d);
        in_use = (a == src) || (b == src) || (c == src) || (d == src);
    endfunction

    // reset release through two flops
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    assign speed_hf  = ctrl_reg[CTRL_SPEED];
    assign setup     = i_psel && !i_penable;
    assign wr_acc    = i_psel && i_penable && i_pwrite;
    assign main_req  = map_src(main_sel_reg);
    assign sub_eff   = map_src(sub_sel_reg ? SRC_XT2 : SRC_RING);
    // failover only while the flag is up and the source is watched
    assign main_eff  = (flag_reg && monitored(main_req, speed_hf)) ? SRC_RING : main_req; // RULE12 RULE19
    assign x1_used   = in_use(SRC_XT1, main_eff, sub_eff, main_cur, sub_cur);
    assign x2_used   = in_use(SRC_XT2, main_eff, sub_eff, main_cur, sub_cur);
    assign ring_used = in_use(SRC_RING, main_eff, sub_eff, main_cur, sub_cur);
    assign osc_run   = {o_crystal_two_en, o_crystal_one_en};
    assign mon_on    = {HAS_XT2, speed_hf}; // RULE15
    assign osc_edge  = {i_crystal_two_clock, i_crystal_one_clock} & ~prev_reg;
    // low-speed crystal one never contributes a fault
    assign fault_sig = (fault_reg[0] && speed_hf) || (fault_reg[1] && HAS_XT2); // RULE15 RULE16
    // low-speed crystal one without crystal two keeps the flag up
    assign flag_clr  = wr_acc && (i_paddr == ADDR_IFG) && !i_pwdata[FLAG_BIT]
                       && (HAS_XT2 || speed_hf); // RULE18 RULE19
    assign acc_next  = {1'b0, acc_reg} + {1'b0, mod_reg};
    // carry of the accumulator spreads the higher steps evenly
    assign hi_step   = acc_next[5] && (step_reg != STEP_MAX); // RULE9 RULE22
    // a dead crystal has no edge to finish on, so the ring lends its edges
    assign main_lvl  = {fault_reg[1] ? i_ring_osc_clock : i_crystal_two_clock,
                        fault_reg[0] ? i_ring_osc_clock : i_crystal_one_clock,
                        i_ring_osc_clock}; // RULE12

    // apb register writes, taken in the access phase
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg     <= CTRL_RST; // RULE6
            step_reg     <= STEP_RST; // RULE6
            mod_reg      <= MOD_RST;
            range_reg    <= RANGE_RST; // RULE6
            main_sel_reg <= SRC_RING; // RULE6
            sub_sel_reg  <= 1'b0; // RULE6
            ie_reg       <= 1'b0;
        end else if (wr_acc) begin
            case (i_paddr)
                ADDR_CTRL: ctrl_reg <= i_pwdata[4:0];
                ADDR_DCO: begin
                    step_reg  <= i_pwdata[DCO_STEP_LSB +: 3]; // RULE8
                    mod_reg   <= i_pwdata[DCO_MOD_LSB +: 5];
                    range_reg <= i_pwdata[DCO_RANGE_LSB +: 3]; // RULE8
                end
                ADDR_CSEL: begin
                    main_sel_reg <= (i_pwdata[1:0] == 2'h3) ? SRC_XT1 : i_pwdata[1:0];
                    sub_sel_reg  <= i_pwdata[CSEL_SUB];
                end
                ADDR_IE:  ie_reg <= i_pwdata[FLAG_BIT];
                default: begin
                    ie_reg <= ie_reg;
                end
            endcase
        end
    end

    // fault flag: set beats clear, hardware never clears it
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= 1'b1;
        end else if (fault_sig) begin
            flag_reg <= 1'b1; // RULE16
        end else if (wr_acc && (i_paddr == ADDR_IFG) && i_pwdata[FLAG_BIT]) begin
            flag_reg <= 1'b1;
        end else if (flag_clr) begin
            flag_reg <= 1'b0; // RULE14
        end
    end

    // interrupt request follows flag and enable
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_nmi_req <= 1'b0;
        end else begin
            o_nmi_req <= flag_reg && ie_reg; // RULE13
        end
    end

    // apb answer: zero wait states, data and error set up in setup
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_prdata  <= 32'h0;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= 1'b1;
            if (setup) begin
                o_pslverr <= 1'b0;
                case (i_paddr)
                    ADDR_CTRL: o_prdata <= {27'h0, ctrl_reg};
                    ADDR_DCO:  o_prdata <= {21'h0, range_reg, mod_reg, step_reg};
                    ADDR_CSEL: o_prdata <= {29'h0, sub_sel_reg, main_sel_reg};
                    ADDR_IE:   o_prdata <= {30'h0, ie_reg, 1'b0};
                    ADDR_IFG:  o_prdata <= {30'h0, flag_reg, 1'b0}; // RULE21
                    ADDR_STAT: o_prdata <= {25'h0, fault_sig, fault_reg, sub_cur, main_cur};
                    default: begin
                        o_prdata  <= 32'h0;
                        o_pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // oscillator controls; an off bit is ignored while its clock is used
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_crystal_one_en <= 1'b1;
            o_crystal_one_hf <= 1'b0;
            o_crystal_two_en <= 1'b1;
            o_ring_osc_en    <= 1'b1;
            o_resistor_ext   <= 1'b0; // RULE6
            o_range_select   <= RANGE_RST;
        end else begin
            o_crystal_one_hf <= speed_hf; // RULE1
            o_crystal_one_en <= !ctrl_reg[CTRL_X1OFF] || x1_used; // RULE2
            o_crystal_two_en <= HAS_XT2 && (!ctrl_reg[CTRL_X2OFF] || x2_used); // RULE3
            // ring stop only honoured in active mode when unused
            o_ring_osc_en    <= !(ctrl_reg[CTRL_ROFF] && i_active_mode) || ring_used; // RULE4
            o_resistor_ext   <= ctrl_reg[CTRL_RES]; // RULE7
            o_range_select   <= range_reg; // RULE8
        end
    end

    // crystal level history for edge detection
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 2'h0;
        end else begin
            prev_reg <= {i_crystal_two_clock, i_crystal_one_clock};
        end
    end

    // fault detectors: absence counter, then presence run to clear
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                absent_reg[i] <= 16'h0;
                good_reg[i]   <= 16'h0;
            end
            fault_reg <= 2'h3; // RULE16
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (osc_edge[i]) begin
                    absent_reg[i] <= 16'h0;
                end else if (absent_reg[i] < 16'(FAULT_CYC)) begin
                    absent_reg[i] <= absent_reg[i] + 16'h1;
                end
                if (!mon_on[i]) begin
                    fault_reg[i] <= 1'b0; // RULE15
                    good_reg[i]  <= 16'h0;
                end else if (!osc_run[i] || absent_reg[i] >= 16'(FAULT_CYC)) begin
                    fault_reg[i] <= 1'b1; // RULE11 RULE17
                    good_reg[i]  <= 16'h0;
                end else if (good_reg[i] >= 16'(FAULT_CYC - 1)) begin
                    fault_reg[i] <= 1'b0; // RULE17
                end else begin
                    good_reg[i] <= good_reg[i] + 16'h1;
                end
            end
        end
    end

    // modulator, one step per ring rising edge
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ring_prev_reg <= 1'b0;
            phase_reg     <= 5'h0;
            acc_reg       <= 5'h0;
            o_ring_step   <= STEP_RST;
        end else begin
            ring_prev_reg <= i_ring_osc_clock;
            if (i_ring_osc_clock && !ring_prev_reg) begin
                phase_reg   <= phase_reg + 5'h1;
                // restart each period so the count is exact per 32 cycles
                acc_reg     <= (phase_reg == PHASE_END) ? 5'h0 : acc_next[4:0]; // RULE10
                o_ring_step <= step_reg + {2'h0, hi_step}; // RULE10
            end
        end
    end

    // glitch-free switches for the two generated clocks
    csfc_clk_switch u_main_sw (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (rst_n),
        .i_src_lvl (main_lvl),
        .i_sel     (main_eff),
        .o_clk     (o_main_clock),
        .o_cur     (main_cur)
    );

    csfc_clk_switch u_sub_sw (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (rst_n),
        .i_src_lvl ({i_crystal_two_clock, i_crystal_one_clock, i_ring_osc_clock}),
        .i_sel     (sub_eff),
        .o_clk     (o_submain_clock),
        .o_cur     (sub_cur)
    );

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n);

    nmi_request_a: assert property (flag_reg && ie_reg |=> o_nmi_req) // RULE13
        else $error("interrupt request missing");
    nmi_quiet_a: assert property (!ie_reg |=> !o_nmi_req) // RULE13
        else $error("interrupt request without enable");
    flag_keep_a: assert property (flag_reg && !flag_clr |=> flag_reg) // RULE14
        else $error("fault flag dropped without clear");
    fault_sets_a: assert property (fault_sig |=> flag_reg) // RULE16
        else $error("fault signal did not set flag");
    lf_no_fault_a: assert property (!speed_hf |=> !fault_reg[0]) // RULE15
        else $error("fault raised in low-speed mode");
    stop_fault_a: assert property (speed_hf && !o_crystal_one_en |=> fault_reg[0]) // RULE17
        else $error("stopped crystal not faulted");
    failover_a: assert property (flag_reg && main_req == SRC_XT2 |-> main_eff == SRC_RING) // RULE12
        else $error("main clock kept faulted crystal");
    lf_stuck_a: assert property (!HAS_XT2 && !speed_hf && flag_reg |=> flag_reg) // RULE18
        else $error("flag cleared in low-speed mode");
    x1_stop_a: assert property (!o_crystal_one_en |-> !(main_cur == SRC_XT1)) // RULE2
        else $error("crystal one stopped while used");
    mod_off_a: assert property ((mod_reg == 5'h0 || step_reg == STEP_MAX) && $stable(step_reg)
        ##1 $stable(step_reg) |-> o_ring_step == step_reg) // RULE9 RULE10
        else $error("modulation active when off");

    flag_rise_c: cover property (!flag_reg ##1 flag_reg);
    failover_c: cover property (main_req != SRC_RING && main_eff == SRC_RING);
    high_step_c: cover property (o_ring_step == step_reg + 3'h1);
endmodule // csfc_top
`default_nettype wire

// [tb_csfc_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_csfc_top;
    import csfc_pkg::*;
    localparam int FC = 20;
    // low dco byte per row: {count, step}
    localparam logic [31:0] ROWS = 32'h47854303;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, prdata2, q;
    logic        x1, x2, xr, act, stall, x1_en, x1_hf, x2_en, r_en, r_ext, nmi, mc, sc;
    logic [2:0]  rng, step;
    int          err_count = 0;
    int          total_checks = 0;

    csfc_top #(.HAS_XT2(1'b1), .FAULT_CYC(FC)) i_csfc_top (
        .i_clk_sys(clk), .i_resetn(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_crystal_one_clock(x1),
        .i_crystal_two_clock(x2), .i_ring_osc_clock(xr), .i_active_mode(act),
        .o_crystal_one_en(x1_en), .o_crystal_one_hf(x1_hf), .o_crystal_two_en(x2_en),
        .o_ring_osc_en(r_en), .o_resistor_ext(r_ext), .o_range_select(rng),
        .o_ring_step(step), .o_main_clock(mc), .o_submain_clock(sc), .o_nmi_req(nmi));
    csfc_osc_model i_csfc_osc_model (.i_clk_sys(clk), .i_en1(x1_en), .i_en2(x2_en),
        .i_enr(r_en), .i_stall(stall), .o_x1(x1), .o_x2(x2), .o_ring(xr));
    // variant without crystal two on the same bus and oscillators; only its flag is read
    csfc_top #(.HAS_XT2(1'b0), .FAULT_CYC(FC)) i_csfc_top_lf (
        .i_clk_sys(clk), .i_resetn(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata2),
        .o_pready(), .o_pslverr(), .i_crystal_one_clock(x1),
        .i_crystal_two_clock(x2), .i_ring_osc_clock(xr), .i_active_mode(act),
        .o_crystal_one_en(), .o_crystal_one_hf(), .o_crystal_two_en(),
        .o_ring_osc_en(), .o_resistor_ext(), .o_range_select(),
        .o_ring_step(), .o_main_clock(), .o_submain_clock(), .o_nmi_req());

    // free-running system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_of_test;
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one apb transfer; an idle edge follows so the next setup never collides
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n <= 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                break;
            end
        end
        check(pready, 1'b1);
        if (pready !== 1'b1) begin
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // polls status until the masked bits match, bounded by n reads
    task automatic wait_stat(input logic [31:0] m, input logic [31:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            apb(1'b0, ADDR_STAT, 32'h0);
            if ((q & m) === v) begin
                break;
            end
        end
        check(q & m, v);
        if ((q & m) !== v) begin
            end_of_test();
        end
    endtask

    task automatic t_reset;
        check({x1_en, x1_hf, x2_en, r_en, r_ext, rng, step}, 11'h5a3);
        apb(1'b0, ADDR_DCO, 32'h0);
        check(q, 32'h403);
        apb(1'b0, ADDR_CSEL, 32'h0);
        check(q, 32'h0);
        apb(1'b0, ADDR_IFG, 32'h0);
        check(q, 32'h2);
        apb(1'b0, 8'h3c, 32'h0);
        check({e, q[30:0]}, 32'h80000000);
    endtask

    task automatic t_fields;
        apb(1'b1, ADDR_CTRL, 32'h11);
        cyc(1);
        check({x1_hf, r_ext}, 2'h3);
        apb(1'b1, ADDR_DCO, 32'h605);
        cyc(8);
        check({rng, step}, 6'h35);
        apb(1'b1, ADDR_CTRL, 32'h0);
        cyc(1);
        check({x1_hf, r_ext}, 2'h0);
    endtask

    // one sample per ring period, 32 samples span one modulation period
    task automatic t_mod;
        logic [7:0] r;
        int         hi;
        int         adj;
        logic       was;
        for (int k = 0; k < 4; k++) begin
            r = ROWS[8 * k +: 8];
            apb(1'b1, ADDR_DCO, {21'h0, 3'h4, r});
            cyc(70);
            hi = 0;
            adj = 0;
            was = 1'b0;
            for (int i = 0; i < 32; i++) begin
                cyc(2);
                adj += int'(was && step !== r[2:0]);
                was = (step !== r[2:0]);
                hi += int'(was);
            end
            check(hi, (r[2:0] == STEP_MAX) ? 0 : r[7:3]);
            check(adj, 0);
        end
    endtask

    task automatic t_xt2;
        logic lv;
        apb(1'b1, ADDR_IFG, 32'h0);
        apb(1'b1, ADDR_CSEL, 32'h6);
        wait_stat(32'hf, 32'ha, 60);
        // both generated clocks now copy crystal two one cycle late
        for (int i = 0; i < 8; i++) begin
            lv = x2;
            cyc(1);
            check({mc, sc}, {lv, lv});
        end
        apb(1'b1, ADDR_CTRL, 32'h4);
        cyc(1);
        check(x2_en, 1'b1);
        act <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h8);
        cyc(1);
        check(r_en, 1'b1);
        act <= 1'b1;
        cyc(4);
        check(r_en, 1'b0);
        // off bits back to zero so every source may run
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_CSEL, 32'h0);
        wait_stat(32'hf, 32'h0, 60);
        apb(1'b1, ADDR_CTRL, 32'h4);
        cyc(3);
        apb(1'b0, ADDR_STAT, 32'h0);
        check({x2_en, q[5]}, 2'h1);
        apb(1'b0, ADDR_IFG, 32'h0);
        check(q, 32'h2);
        apb(1'b1, ADDR_CTRL, 32'h0);
        cyc(FC - 6);
        apb(1'b0, ADDR_STAT, 32'h0);
        check(q[5], 1'b1);
        wait_stat(32'h20, 32'h0, 20);
    endtask

    task automatic t_xt1;
        apb(1'b1, ADDR_CTRL, 32'h1);
        cyc(3 * FC);
        apb(1'b1, ADDR_IFG, 32'h0);
        apb(1'b1, ADDR_CSEL, 32'h1);
        wait_stat(32'h3, 32'h1, 60);
        apb(1'b1, ADDR_CTRL, 32'h3);
        cyc(1);
        check(x1_en, 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h1);
        stall <= 1'b1;
        cyc(FC - 10);
        apb(1'b0, ADDR_STAT, 32'h0);
        check(q[4], 1'b0);
        wait_stat(32'h13, 32'h10, 20);
        apb(1'b0, ADDR_IFG, 32'h0);
        check(q, 32'h2);
        apb(1'b1, ADDR_IE, 32'h2);
        cyc(2);
        check(nmi, 1'b1);
        stall <= 1'b0;
        cyc(3 * FC);
        apb(1'b0, ADDR_IFG, 32'h0);
        check(q, 32'h2);
        apb(1'b1, ADDR_IFG, 32'h0);
        apb(1'b0, ADDR_IFG, 32'h0);
        check({nmi, q[1]}, 2'h0);
    endtask

    task automatic t_lf;
        apb(1'b1, ADDR_CSEL, 32'h0);
        wait_stat(32'h3, 32'h0, 60);
        apb(1'b1, ADDR_CTRL, 32'h3);
        cyc(1);
        check(x1_en, 1'b0);
        apb(1'b0, ADDR_STAT, 32'h0);
        check(q[4], 1'b1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        stall <= 1'b1;
        cyc(3 * FC);
        apb(1'b1, ADDR_IFG, 32'h0);
        apb(1'b0, ADDR_STAT, 32'h0);
        check(q[4], 1'b0);
        apb(1'b0, ADDR_IFG, 32'h0);
        check(q, 32'h0);
        check(prdata2, 32'h2);
        stall <= 1'b0;
        apb(1'b1, ADDR_IFG, 32'h2);
        apb(1'b1, ADDR_CSEL, 32'h1);
        wait_stat(32'h3, 32'h1, 60);
    endtask

    // reset for two cycles, then the scenarios in turn
    initial begin
        {psel, penable, pwrite, paddr, pwdata, stall, rst_n} = '0;
        act = 1'b1;
        cyc(2);
        rst_n <= 1'b1;
        cyc(3);
        t_reset();
        t_fields();
        t_mod();
        t_xt2();
        t_xt1();
        t_lf();
        end_of_test();
    end
endmodule // tb_csfc_top
`default_nettype wire
